// ---- rtl/psu_i2c_slave_addressing.sv ----
/*
 * Management bus slave of the supply: strap-selected address match,
 * byte transfer, and monitors for transaction spacing and clock rate.
 * Assumes an external pull-up on SCL and SDA and a master on the far side.
 */
// Summary of operation
// - Address is base with straps at bits 2:1
// - Straps pick 0xB0/B2/B4/B6, read address plus one
// - Open straps read high, highest address
// - Host masters bus; supply never drives clock
// - One address serves commands and unit data
// - Bus clock stays within 10 to 100 kHz
// - Command bytes serviced only while powered
`timescale 1ns/1ps
module psu_i2c_slave_addressing
   import psu_pkg::*;
#(
   parameter int GAP_CYCLES    = psu_pkg::GAP_CYC,
   parameter int PER_MAX_CYCLES = psu_pkg::PER_MAX_CYC
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rstn,
   // Bus pins; SCL is input only
   input  wire logic                   scl_i,
   input  wire logic                   sda_i,
   output logic                        sda_o,
   output logic                        sda_oe,
   // Slot straps and power state
   input  wire logic                   slot_addr_strap_lo,
   input  wire logic                   slot_addr_strap_hi,
   input  wire logic                   power_good,
   // Byte side
   output psu_pkg::rx_byte_t           rx,
   input  wire logic [7:0]             tx_data,
   output logic                        tx_req,
   // Status
   output psu_pkg::slave_status_t      stat
);
   import psu_pkg::*;

   // ***********************************************************
   // Checks and synchronisers
   // ***********************************************************
   if (GAP_CYCLES < 1 || GAP_CYCLES >= (1 << CNT_W) - 1)
   begin : g_gap_chk
      $error("GAP_CYCLES out of counter range");
   end
   if (PER_MAX_CYCLES <= PER_MIN_CYC || PER_MAX_CYCLES >= (1 << CNT_W) - 1)
   begin : g_per_chk
      $error("PER_MAX_CYCLES out of counter range");
   end

   localparam logic [CNT_W-1:0] GAP_LIM = CNT_W'(GAP_CYCLES);
   localparam logic [CNT_W-1:0] PER_MIN = CNT_W'(PER_MIN_CYC);
   localparam logic [CNT_W-1:0] PER_MAX = CNT_W'(PER_MAX_CYCLES);

   logic [1:0] straps;
   logic       scl_s;
   logic       sda_s;
   logic       pwr_s;

   // Pull-ups make an open strap a one, so reset matches that
   sync2 #(.W(2), .RST(STRAP_OPEN)) u_strap_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  ({slot_addr_strap_hi, slot_addr_strap_lo}),
      .dout (straps)
   );
   sync2 #(.W(3), .RST(3'h6)) u_bus_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  ({scl_i, sda_i, power_good}),
      .dout ({scl_s, sda_s, pwr_s})
   );

   // ***********************************************************
   // Bus engine
   // ***********************************************************
   slave_state_t q;
   slave_state_t d;
   logic         rise;
   logic         fall;
   logic         start;
   logic         stop;

   assign rise  = scl_s & ~q.scl_p;
   assign fall  = ~scl_s & q.scl_p;
   assign start = scl_s & q.scl_p & q.sda_p & ~sda_s;
   assign stop  = scl_s & q.scl_p & ~q.sda_p & sda_s;

   always_comb
   begin
      d          = q;
      d.rx.valid = 1'b0;
      d.tx_req   = 1'b0;
      d.scl_p    = scl_s;
      d.sda_p    = sda_s;
      // Same address for command space and unit data
      d.stat.own_addr = BASE_ADDR | (8'(straps) << STRAP_POS);
      if (q.gap_armed && q.gap_cnt != GAP_LIM)
         d.gap_cnt = q.gap_cnt + CNT_W'(1);
      if (q.per_cnt != '1)
         d.per_cnt = q.per_cnt + CNT_W'(1);

      if (start)
      begin
         // Flag a master that came back too soon
         d.stat.space_fault = q.gap_armed && q.gap_cnt < GAP_LIM;
         d.gap_armed       = 1'b0;
         d.stat.rate_fault = 1'b0;
         d.stat.addressed  = 1'b0;
         d.seen_rise       = 1'b0;
         d.st              = ST_ADDR;
         d.cnt             = '0;
         d.sda_oe          = 1'b0;
      end
      else if (stop)
      begin
         d.st        = ST_IDLE;
         d.sda_oe    = 1'b0;
         d.gap_armed = q.stat.addressed;
         d.gap_cnt   = '0;
      end
      else
      begin
         if (rise)
         begin
            // Period between rising edges must sit inside the rate window
            if (q.seen_rise && (q.per_cnt < PER_MIN || q.per_cnt > PER_MAX))
               d.stat.rate_fault = 1'b1;
            d.seen_rise = 1'b1;
            d.per_cnt   = '0;
         end
         case (q.st)
            ST_ADDR, ST_WRITE:
            begin
               if (rise)
               begin
                  d.shreg = {q.shreg[6:0], sda_s};
                  d.cnt   = q.cnt + 4'h1;
               end
               else if (fall && q.cnt == BYTE_BITS)
               begin
                  if (q.st == ST_WRITE)
                  begin
                     // Unpowered: acknowledge but do not deliver
                     d.rx.valid = pwr_s;
                     d.rx.first = q.first;
                     d.rx.data  = q.shreg;
                     d.first    = 1'b0;
                     d.sda_oe   = 1'b1;
                     d.st       = ST_WACK;
                  end
                  else if (q.shreg[7:1] == q.stat.own_addr[7:1])
                  begin
                     d.sda_oe         = 1'b1;
                     d.rw             = q.shreg[0];
                     d.first          = 1'b1;
                     d.stat.addressed = 1'b1;
                     d.st             = ST_AACK;
                  end
                  else
                     d.st = ST_IGNORE;
               end
            end
            ST_AACK, ST_WACK, ST_RACK:
            begin
               if (rise)
                  d.nack = sda_s;
               else if (fall)
               begin
                  d.cnt = '0;
                  if (q.st == ST_RACK && q.nack)
                  begin
                     d.sda_oe = 1'b0;
                     d.st     = ST_IGNORE;
                  end
                  else if (q.st == ST_RACK || (q.st == ST_AACK && q.rw))
                  begin
                     d.shreg  = tx_data;
                     d.tx_req = 1'b1;
                     d.sda_oe = ~tx_data[7];
                     d.st     = ST_READ;
                  end
                  else
                  begin
                     d.sda_oe = 1'b0;
                     d.st     = ST_WRITE;
                  end
               end
            end
            ST_READ:
            begin
               if (rise)
                  d.cnt = q.cnt + 4'h1;
               else if (fall)
               begin
                  if (q.cnt == BYTE_BITS)
                  begin
                     d.sda_oe = 1'b0;
                     d.st     = ST_RACK;
                  end
                  else
                  begin
                     d.shreg  = {q.shreg[6:0], 1'b0};
                     d.sda_oe = ~q.shreg[6];
                  end
               end
            end
            default:
               d.sda_oe = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         q               <= '0;
         q.st            <= ST_IDLE;
         q.scl_p         <= 1'b1;
         q.sda_p         <= 1'b1;
         q.stat.own_addr <= ADDR_WR_11;
      end
      else
         q <= d;
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   // Pin is open drain: only ever pulled low, and SCL is never driven
   assign sda_o  = 1'b0;
   assign sda_oe = q.sda_oe;
   assign rx     = q.rx;
   assign tx_req = q.tx_req;
   assign stat   = q.stat;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   sequence s_addr_done;
      q.st == ST_ADDR && fall && q.cnt == BYTE_BITS;
   endsequence

   a_addr_form: assert property (@(posedge clk) disable iff (!rstn)
      q.stat.own_addr == ($past(BASE_ADDR | {5'h0, straps, 1'b0}))
      && (q.stat.own_addr | 8'h01) == q.stat.own_addr + 8'h01)
      else $error("own address not base plus straps");
   a_addr_table: assert property (@(posedge clk) disable iff (!rstn)
      (($past(straps) == 2'h3) |-> q.stat.own_addr == ADDR_WR_11
            && (q.stat.own_addr | 8'h01) == ADDR_RD_11)
      and (($past(straps) == 2'h2) |-> q.stat.own_addr == ADDR_WR_10)
      and (($past(straps) == 2'h1) |-> q.stat.own_addr == ADDR_WR_01)
      and (($past(straps) == 2'h0) |-> (q.stat.own_addr | 8'h01) == ADDR_RD_00))
      else $error("address table mismatch");
   a_strap_open: assert property (@(posedge clk) disable iff (!rstn)
      !$past(rstn) |-> straps == STRAP_OPEN && q.stat.own_addr == ADDR_WR_11)
      else $error("straps not high out of reset");
   a_slave_only: assert property (@(posedge clk) disable iff (!rstn)
      sda_oe |-> (q.st inside {ST_AACK, ST_WACK, ST_READ}) && sda_o == 1'b0)
      else $error("data line driven outside a slave slot");
   a_ack_match: assert property (@(posedge clk) disable iff (!rstn)
      s_addr_done ##0 ((q.shreg[7:1] == q.stat.own_addr[7:1]) && !start && !stop)
      |=> q.st == ST_AACK && sda_oe && stat.addressed)
      else $error("own address not acknowledged");
   a_gap_flag: assert property (@(posedge clk) disable iff (!rstn)
      start && q.gap_armed && q.gap_cnt < GAP_LIM |=> stat.space_fault)
      else $error("short spacing not flagged");
   a_rate_flag: assert property (@(posedge clk) disable iff (!rstn)
      rise && !start && !stop && q.seen_rise && q.per_cnt < PER_MIN
      |=> stat.rate_fault [*1] ##1 (stat.rate_fault || $past(start)))
      else $error("fast clock not flagged");
   a_rx_power: assert property (@(posedge clk) disable iff (!rstn)
      rx.valid |-> $past(pwr_s) && $past(q.st) == ST_WRITE)
      else $error("byte delivered while unpowered");
   a_nomatch_quiet: assert property (@(posedge clk) disable iff (!rstn)
      s_addr_done ##0 ((q.shreg[7:1] != q.stat.own_addr[7:1]) && !start && !stop)
      |=> (!sda_oe && q.st == ST_IGNORE) [*2])
      else $error("foreign address acknowledged");
endmodule

// ---- rtl/psu_pkg.sv ----
/*
 * Constants and shared types of the supply's management bus slave.
 * Assumes a 50 MHz system clock; all timing counts derive from it.
 */
package psu_pkg;

   // ***********************************************************
   // Addressing
   // ***********************************************************
   localparam logic [7:0] BASE_ADDR   = 8'hB0;
   localparam logic [7:0] ADDR_WR_11  = 8'hB6;
   localparam logic [7:0] ADDR_RD_11  = 8'hB7;
   localparam logic [7:0] ADDR_WR_10  = 8'hB4;
   localparam logic [7:0] ADDR_WR_01  = 8'hB2;
   localparam logic [7:0] ADDR_WR_00  = 8'hB0;
   localparam logic [7:0] ADDR_RD_00  = 8'hB1;
   localparam int         STRAP_POS   = 1;
   localparam logic [1:0] STRAP_OPEN  = 2'h3;
   localparam logic [3:0] BYTE_BITS   = 4'h8;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int CLK_HZ     = 50_000_000;
   localparam int GAP_MS     = 15;
   localparam int F_MIN_HZ   = 10_000;
   localparam int F_MAX_HZ   = 100_000;
   // Gap is exact, least period rounds up, longest period rounds down; all exact at this rate
   localparam int GAP_CYC    = (GAP_MS * (CLK_HZ / 1000) + 0);
   localparam int PER_MIN_CYC = (CLK_HZ + F_MAX_HZ - 1) / F_MAX_HZ;
   localparam int PER_MAX_CYC = CLK_HZ / F_MIN_HZ;
   localparam int CNT_W      = 20;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_ADDR   = 3'h1,
      ST_AACK   = 3'h3,
      ST_WRITE  = 3'h2,
      ST_WACK   = 3'h6,
      ST_READ   = 3'h7,
      ST_RACK   = 3'h5,
      ST_IGNORE = 3'h4
   } bus_state_t;

   typedef struct packed {
      logic       valid;
      logic       first;
      logic [7:0] data;
   } rx_byte_t;

   typedef struct packed {
      logic       space_fault;
      logic       rate_fault;
      logic       addressed;
      logic [7:0] own_addr;
   } slave_status_t;

   typedef struct packed {
      bus_state_t       st;
      logic [3:0]       cnt;
      logic [7:0]       shreg;
      logic             rw;
      logic             nack;
      logic             first;
      logic             scl_p;
      logic             sda_p;
      logic             sda_oe;
      logic             tx_req;
      logic             seen_rise;
      logic             gap_armed;
      logic [CNT_W-1:0] gap_cnt;
      logic [CNT_W-1:0] per_cnt;
      rx_byte_t         rx;
      slave_status_t    stat;
   } slave_state_t;

endpackage

// ---- rtl/sync2.sv ----
/*
 * Two-stage synchroniser for a bundle of pin levels.
 * Assumes inputs are asynchronous levels; the reset value is a parameter.
 */
`timescale 1ns/1ps
module sync2 #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // Levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_q <= RST;
         dout   <= RST;
      end
      else
      begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

// ---- tb/host_model.sv ----
/*
 * Bus master model for the supply's management bus slave.
 * Assumes the bench resolves SDA from both enables with a pull-up.
 */
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire logic clk,
   // Bus
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_oe
);
   int half = 260;
   // Only the host drives the clock
   initial
   begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Wait w before START; bench keeps w above the gap except on purpose
   task automatic start(input int w);
      tick(w);
      sda_oe = 1'b1;
      tick(half);
      scl = 1'b0;
   endtask
   // Data moves 2 clk after the fall so the slave never sees a false START
   // Rise to rise is 2*half: 520 clk stays inside 10 to 100 kHz
   task automatic bit_io(input logic b, output logic s);
      tick(2);
      sda_oe = ~b;
      tick(half - 2);
      scl = 1'b1;
      tick(half);
      s = sda_line;
      scl = 1'b0;
   endtask
   task automatic stop();
      tick(2);
      sda_oe = 1'b1;
      tick(half - 2);
      scl = 1'b1;
      tick(half);
      sda_oe = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic rbyte(input logic ackm, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(~ackm, s);
   endtask
endmodule

// ---- tb/psu_i2c_slave_addressing_tb_top.sv ----
/*
 * Self-checking bench for the management bus slave.
 * Assumes the host model in the same folder and the small gap parameter.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module psu_i2c_slave_addressing_tb_top;
   import psu_pkg::*;
   logic          clk = 1'b0;
   logic          rstn = 1'b0;
   logic          scl, host_oe, sda_o, sda_oe, sda_line;
   logic          strap_lo;
   logic          strap_hi;
   logic          power_good;
   logic [7:0]    tx_data;
   int            tx_req_cnt = 0;
   logic          tx_req;
   rx_byte_t      rx, rx_last;
   slave_status_t stat;
   int            miscompares = 0;
   int            checks = 0;
   int            rx_cnt = 0;
   logic          ack;
   logic [7:0]    rb;

   always #10 clk = ~clk;
   // Pull-up: either party pulling low wins
   assign sda_line = ~(host_oe | sda_oe);
   always @(posedge clk)
   begin
      if (rx.valid === 1'b1)
      begin
         rx_cnt++;
         rx_last <= rx;
      end
      if (tx_req === 1'b1)
         tx_req_cnt++;
   end

   psu_i2c_slave_addressing #(.GAP_CYCLES(200), .PER_MAX_CYCLES(5000)) u_psu_i2c_slave_addressing (
      .clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
      .slot_addr_strap_lo(strap_lo), .slot_addr_strap_hi(strap_hi), .power_good(power_good),
      .rx(rx), .tx_data(tx_data), .tx_req(tx_req), .stat(stat));
   host_model u_host_model (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_oe(host_oe));

   task automatic give_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic test_reset();
      `CHK("sda_oe", 1'b0, sda_oe)
      `CHK("own_addr", 8'hB6, stat.own_addr)
      `CHK("sda_o", 1'b0, sda_o)
      `CHK("addressed", 1'b0, stat.addressed)
   endtask
   // Every strap setting, ending at 00, each answered at its own write address
   task automatic test_straps();
      logic [7:0] exp;
      for (int i = 3; i >= 0; i--)
      begin
         strap_hi = i[1];
         strap_lo = i[0];
         exp = (i == 3) ? ADDR_WR_11 : (i == 2) ? ADDR_WR_10 :
               (i == 1) ? ADDR_WR_01 : ADDR_WR_00;
         u_host_model.tick(8);
         `CHK("own_addr", exp, stat.own_addr)
         u_host_model.start(260);
         u_host_model.wbyte(exp, ack);
         u_host_model.stop();
         `CHK("addr ack", 1'b1, ack)
      end
   endtask
   // Straps are 00 here: the open-strap address must be refused
   task automatic test_mismatch();
      u_host_model.start(260);
      u_host_model.wbyte(8'hB6, ack);
      u_host_model.stop();
      `CHK("mismatch ack", 1'b0, ack)
      `CHK("mismatch addressed", 1'b0, stat.addressed)
   endtask
   task automatic test_write(input logic pg);
      int n;
      power_good = pg;
      n = rx_cnt;
      u_host_model.tick(8);
      u_host_model.start(260);
      u_host_model.wbyte(8'hB0, ack);
      `CHK("addr ack", 1'b1, ack)
      `CHK("addressed", 1'b1, stat.addressed)
      u_host_model.wbyte(8'h3C, ack);
      u_host_model.stop();
      `CHK("data ack", 1'b1, ack)
      `CHK("rx count", n + int'(pg), rx_cnt)
      if (pg)
      begin
         `CHK("rx data", 8'h3C, rx_last.data)
         `CHK("rx first", 1'b1, rx_last.first)
      end
      power_good = 1'b1;
   endtask
   // Two bytes: the host acknowledges the first and refuses the second
   task automatic test_read();
      int n;
      n = tx_req_cnt;
      tx_data = 8'h5A;
      u_host_model.start(260);
      u_host_model.wbyte(ADDR_RD_00, ack);
      `CHK("read addr ack", 1'b1, ack)
      u_host_model.rbyte(1'b1, rb);
      tx_data = 8'hC3;
      `CHK("read data 0", 8'h5A, rb)
      u_host_model.rbyte(1'b0, rb);
      u_host_model.stop();
      `CHK("read data 1", 8'hC3, rb)
      `CHK("tx_req count", n + 2, tx_req_cnt)
   endtask
   task automatic test_faults();
      u_host_model.start(20);
      u_host_model.tick(8);
      `CHK("space fault", 1'b1, stat.space_fault)
      u_host_model.stop();
      u_host_model.start(260);
      u_host_model.tick(8);
      `CHK("space clear", 1'b0, stat.space_fault)
      // Rise to rise of 5200 clk is slower than the lowest legal rate
      u_host_model.half = 2600;
      u_host_model.bit_io(1'b1, ack);
      u_host_model.bit_io(1'b1, ack);
      u_host_model.half = 260;
      u_host_model.tick(8);
      `CHK("rate fault slow", 1'b1, stat.rate_fault)
      u_host_model.stop();
      u_host_model.start(260);
      u_host_model.tick(8);
      `CHK("rate clear", 1'b0, stat.rate_fault)
      // Rise to rise of 400 clk is faster than the highest legal rate
      u_host_model.half = 200;
      u_host_model.bit_io(1'b1, ack);
      u_host_model.bit_io(1'b1, ack);
      u_host_model.half = 260;
      u_host_model.tick(8);
      `CHK("rate fault fast", 1'b1, stat.rate_fault)
      u_host_model.stop();
   endtask

   initial
   begin
      strap_lo = 1'b1;
      strap_hi = 1'b1;
      power_good = 1'b1;
      tx_data = 8'hA5;
      repeat (4) @(posedge clk);
      #1;
      rstn = 1'b1;
      u_host_model.tick(6);
      test_reset();
      test_straps();
      test_mismatch();
      test_write(1'b1);
      test_write(1'b0);
      test_read();
      test_faults();
      give_verdict();
   end
   // Tests need about 79000 cycles
   initial
   begin
      repeat (99000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
endmodule
